// ==== rtl/fsc_cfg.svh ====
/*
 * Constants of the serial channel: FIFO depth, bit timing, flag positions.
 * Assumes it is included by bare name from files under rtl/.
 */
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH

`define FSC_DEPTH 16
`define FSC_CNT_W 5
`define FSC_OS_MID 4'h7
`define FSC_OS_RISE 4'h8
`define FSC_OS_LAST 4'hF
`define FSC_BIT_LAST 3'h7
`define FSC_RTS_LVL 5'h0E
`define FSC_ERR_FRM 0
`define FSC_ERR_PAR 1
`define FSC_ERR_BRK 2
`define FSC_ERR_OVR 3

`endif

// ==== rtl/fsc_channel.sv ====
/*
 * One serial channel: 16-byte transmit and receive FIFOs, asynchronous or
 * master synchronous mode, threshold, end and error events.
 * Assumes one clock; rxd_in and cts_n_in come from pins.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fsc_cfg.svh"

module fsc_channel import fsc_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Transmit bytes from host
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // Received bytes to host
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   // Configuration
   input wire logic mode_sync,
   input wire logic parity_en,
   input wire logic parity_odd,
   input wire logic stop2,
   input wire logic msb_first,
   input wire logic noise_cancel_en,
   input wire logic flow_ctrl_en,
   input wire logic [15:0] baud_div,
   input wire logic [3:0] tx_thresh,
   input wire logic [4:0] rx_thresh,
   // Error flags: write-zero strobes and state
   input wire logic [3:0] err_clr_zero,
   output logic [3:0] err_flags,
   // Events
   output logic tx_threshold_event,
   output logic tx_end_event,
   output logic rx_threshold_event,
   output logic rx_error_event,
   output logic break_overrun_event,
   // Serial line
   input wire logic rxd_in,
   input wire logic cts_n_in,
   output logic txd_out,
   output logic sck_out,
   output logic rts_n_out
);
   fsc_state_t tx_st_r, rx_st_r;
   logic [15:0] div_r;
   logic os_tick;
   logic rxd_s1_r, rxd_s2_r, cts_s1_r, cts_s2_r;
   logic [2:0] nf_r;
   logic rx_line;
   logic [7:0] txf_data, rxf_data, tx_sh_r, rx_sh_r, rx_shv, rx_word_r;
   logic txf_valid, txf_ready, rxf_ready, tx_pop, tx_bit_end, tx_last;
   logic [4:0] txf_cnt, rxf_cnt;
   logic [3:0] tx_os_r, rx_os_r, err_r, err_set;
   logic [2:0] tx_bit_r, rx_bit_r;
   logic tx_par_r, tx_stop2_r, rx_par_r, txd_r, sck_r, rts_n_r;
   logic rx_mid, rx_end, sync_smp, rx_push_r;
   logic frm_p_r, par_p_r, brk_p_r;
   logic tx_end_r, tx_thr_r, rx_thr_r, rx_err_r, brk_ovr_r;

   // Oversample tick: sixteen per bit, period baud_div + 1
   assign os_tick = div_r == 16'h0000;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) div_r <= 16'h0000;
      else div_r <= os_tick ? baud_div : div_r - 16'h0001;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {rxd_s1_r, rxd_s2_r, cts_s1_r, cts_s2_r} <= 4'hF;
         nf_r <= 3'h7;
      end else begin
         {rxd_s1_r, rxd_s2_r} <= {rxd_in, rxd_s1_r};
         {cts_s1_r, cts_s2_r} <= {cts_n_in, cts_s1_r};
         if (os_tick) nf_r <= {nf_r[1:0], rxd_s2_r};
      end
   end
   // Majority of three ticks rejects single-tick glitches
   assign rx_line = (noise_cancel_en && !mode_sync) ?
      ((nf_r[0] & nf_r[1]) | (nf_r[1] & nf_r[2]) | (nf_r[0] & nf_r[2])) :
      rxd_s2_r;

   fsc_fifo #(.W(8), .D(`FSC_DEPTH)) u_txf (
      .clk(clk), .resetn(resetn),
      .in_data(tx_data), .in_valid(tx_valid), .in_ready(txf_ready),
      .out_data(txf_data), .out_valid(txf_valid), .out_ready(tx_pop),
      .count(txf_cnt));
   assign tx_ready = txf_ready;

   // Start as soon as a byte waits; CTS only gates async starts
   assign tx_pop = tx_st_r == S_IDLE && txf_valid &&
      (mode_sync || !flow_ctrl_en || !cts_s2_r);
   assign tx_bit_end = os_tick && tx_os_r == `FSC_OS_LAST;
   assign tx_last = tx_bit_end &&
      ((tx_st_r == S_STOP && (!stop2 || tx_stop2_r)) ||
       (tx_st_r == S_DATA && mode_sync && tx_bit_r == `FSC_BIT_LAST));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_st_r <= S_IDLE;
         tx_os_r <= 4'h0;
         tx_bit_r <= 3'h0;
         tx_sh_r <= 8'h00;
         tx_par_r <= 1'b0;
         tx_stop2_r <= 1'b0;
      end else begin
         if (os_tick) tx_os_r <= tx_os_r + 4'h1;
         unique case (tx_st_r)
            S_IDLE: if (tx_pop) begin
               tx_st_r <= mode_sync ? S_DATA : S_START;
               tx_os_r <= 4'h0;
               tx_bit_r <= 3'h0;
               tx_sh_r <= msb_first ? {<<{txf_data}} : txf_data;
               tx_par_r <= parity_odd;
               tx_stop2_r <= 1'b0;
            end
            S_START: if (tx_bit_end) tx_st_r <= S_DATA;
            S_DATA: if (tx_bit_end) begin
               tx_sh_r <= {1'b0, tx_sh_r[7:1]};
               tx_par_r <= tx_par_r ^ tx_sh_r[0];
               tx_bit_r <= tx_bit_r + 3'h1;
               if (tx_bit_r == `FSC_BIT_LAST)
                  tx_st_r <= mode_sync ? S_IDLE :
                     (parity_en ? S_PAR : S_STOP);
            end
            S_PAR: if (tx_bit_end) tx_st_r <= S_STOP;
            S_STOP: if (tx_bit_end) begin
               tx_stop2_r <= 1'b1;
               if (tx_last) tx_st_r <= S_IDLE;
            end
         endcase
      end
   end

   // Line idles high; sync clock low in first half of each bit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txd_r <= 1'b1;
         sck_r <= 1'b1;
      end else begin
         txd_r <= tx_st_r == S_START ? 1'b0 :
            tx_st_r == S_DATA ? tx_sh_r[0] :
            tx_st_r == S_PAR ? tx_par_r : 1'b1;
         sck_r <= !(mode_sync && tx_st_r == S_DATA &&
            tx_os_r < `FSC_OS_RISE);
      end
   end

   // Sync receive samples at the rising edge of the clock
   assign sync_smp = mode_sync && tx_st_r == S_DATA && os_tick &&
      tx_os_r == `FSC_OS_RISE;
   assign rx_mid = os_tick && rx_os_r == `FSC_OS_MID;
   assign rx_end = os_tick && rx_os_r == `FSC_OS_LAST;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_st_r <= S_IDLE;
         rx_os_r <= 4'h0;
         rx_bit_r <= 3'h0;
         rx_sh_r <= 8'h00;
         rx_par_r <= 1'b0;
      end else if (mode_sync) begin
         rx_st_r <= S_IDLE;
         if (sync_smp) rx_sh_r <= {rxd_s2_r, rx_sh_r[7:1]};
      end else begin
         if (os_tick) rx_os_r <= rx_os_r + 4'h1;
         unique case (rx_st_r)
            S_IDLE: if (os_tick && !rx_line) begin
               rx_st_r <= S_START;
               rx_os_r <= 4'h0;
            end
            // A start bit gone high by mid-bit was a glitch
            S_START: if (rx_mid && rx_line) rx_st_r <= S_IDLE;
               else if (rx_end) begin
                  rx_st_r <= S_DATA;
                  rx_bit_r <= 3'h0;
                  rx_par_r <= parity_odd;
               end
            S_DATA: begin
               if (rx_mid) begin
                  rx_sh_r <= {rx_line, rx_sh_r[7:1]};
                  rx_par_r <= rx_par_r ^ rx_line;
               end
               if (rx_end) begin
                  rx_bit_r <= rx_bit_r + 3'h1;
                  if (rx_bit_r == `FSC_BIT_LAST)
                     rx_st_r <= parity_en ? S_PAR : S_STOP;
               end
            end
            S_PAR: if (rx_end) rx_st_r <= S_STOP;
            // Back to idle at mid stop bit to resync on the next start
            S_STOP: if (rx_mid) rx_st_r <= S_IDLE;
         endcase
      end
   end

   assign rx_shv = mode_sync ? {rxd_s2_r, rx_sh_r[7:1]} : rx_sh_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_push_r <= 1'b0;
         rx_word_r <= 8'h00;
         {frm_p_r, par_p_r, brk_p_r} <= 3'h0;
      end else begin
         rx_push_r <= mode_sync ? sync_smp && tx_bit_r == `FSC_BIT_LAST :
            rx_st_r == S_STOP && rx_mid;
         rx_word_r <= msb_first ? {<<{rx_shv}} : rx_shv;
         frm_p_r <= rx_st_r == S_STOP && rx_mid && !rx_line;
         par_p_r <= rx_st_r == S_PAR && rx_mid &&
            (rx_par_r ^ rx_line);
         brk_p_r <= rx_st_r == S_STOP && rx_mid && !rx_line &&
            rx_sh_r == 8'h00;
      end
   end

   // Bytes wait here until read; a full FIFO drops the new byte
   fsc_fifo #(.W(8), .D(`FSC_DEPTH)) u_rxf (
      .clk(clk), .resetn(resetn),
      .in_data(rx_word_r), .in_valid(rx_push_r), .in_ready(rxf_ready),
      .out_data(rxf_data), .out_valid(rx_valid), .out_ready(rx_ready),
      .count(rxf_cnt));
   assign rx_data = rxf_data;

   assign err_set[`FSC_ERR_FRM] = frm_p_r;
   assign err_set[`FSC_ERR_PAR] = par_p_r;
   assign err_set[`FSC_ERR_BRK] = brk_p_r;
   assign err_set[`FSC_ERR_OVR] = rx_push_r && !rxf_ready;
   // A new error in the clearing cycle stays set
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) err_r <= 4'h0;
      else err_r <= (err_r & ~err_clr_zero) | err_set;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {tx_thr_r, rx_thr_r, rx_err_r, brk_ovr_r} <= 4'h0;
         tx_end_r <= 1'b0;
         rts_n_r <= 1'b0;
      end else begin
         tx_thr_r <= txf_cnt <= {1'b0, tx_thresh};
         rx_thr_r <= rxf_cnt >= rx_thresh;
         rx_err_r <= err_r[`FSC_ERR_FRM] | err_r[`FSC_ERR_PAR];
         brk_ovr_r <= err_r[`FSC_ERR_BRK] | err_r[`FSC_ERR_OVR];
         if (tx_valid && txf_ready) tx_end_r <= 1'b0;
         else if (tx_last && !txf_valid) tx_end_r <= 1'b1;
         // Two spare slots cover bytes already in flight
         rts_n_r <= flow_ctrl_en && !mode_sync &&
            rxf_cnt >= `FSC_RTS_LVL;
      end
   end

   assign err_flags = err_r;
   assign tx_threshold_event = tx_thr_r;
   assign tx_end_event = tx_end_r;
   assign rx_threshold_event = rx_thr_r;
   assign rx_error_event = rx_err_r;
   assign break_overrun_event = brk_ovr_r;
   assign txd_out = txd_r;
   assign sck_out = sck_r;
   assign rts_n_out = rts_n_r;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   tx_kick_a: assert property (tx_pop |=> tx_st_r != S_IDLE)
      else $error("idle transmitter did not start");
   start_low_a: assert property (
      tx_st_r == S_START |=> txd_out == 1'b0)
      else $error("start bit not low");
   tx_end_a: assert property (
      $rose(tx_end_event) |-> txf_cnt == 5'h00 && tx_st_r == S_IDLE)
      else $error("tx end raised with data left");
   tx_thr_a: assert property (
      txf_cnt <= {1'b0, tx_thresh} |=> tx_threshold_event)
      else $error("tx threshold event missing");
   rx_thr_a: assert property (
      rxf_cnt < rx_thresh |=> !rx_threshold_event)
      else $error("rx threshold event early");
   frm_flag_a: assert property (
      rx_st_r == S_STOP && rx_mid && !rx_line |=> ##1
      err_flags[`FSC_ERR_FRM] ##1 rx_error_event)
      else $error("framing error not flagged");
   ovr_flag_a: assert property (
      rx_push_r && !rxf_ready |=> err_flags[`FSC_ERR_OVR] ##1
      break_overrun_event)
      else $error("overrun not flagged");
   clr_zero_a: assert property (
      err_clr_zero[`FSC_ERR_PAR] && !par_p_r |=> !err_flags[`FSC_ERR_PAR])
      else $error("parity flag not cleared");
   rts_hold_a: assert property (
      flow_ctrl_en && !mode_sync && rxf_cnt >= `FSC_RTS_LVL |=> rts_n_out)
      else $error("rts not raised near full");
   sck_low_a: assert property (
      mode_sync && tx_st_r == S_DATA && tx_os_r == 4'h0 |=> !sck_out)
      else $error("sync clock not low in first half");

   tx_done_c: cover property ($rose(tx_end_event));
   rx_full_c: cover property (rxf_cnt == 5'h10);
   frm_err_c: cover property ($rose(err_flags[`FSC_ERR_FRM]));
   sync_byte_c: cover property (mode_sync && rx_push_r);
endmodule // fsc_channel

`default_nettype wire

// ==== rtl/fsc_fifo.sv ====
/*
 * Synchronous FIFO with valid/ready on both sides and a fill count.
 * Assumes one clock; depth is a power of two.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fsc_cfg.svh"

module fsc_fifo #(
   parameter int W = 8,
   parameter int D = `FSC_DEPTH,
   parameter int AW = $clog2(D)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Filling side
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Draining side
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   // Fill level
   output logic [AW:0] count
);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic wr_en;
   logic rd_en;

   assign in_ready = cnt_r != (AW+1)'(D);
   assign out_valid = cnt_r != '0;
   assign out_data = mem[rd_r];
   assign count = cnt_r;
   assign wr_en = in_valid && in_ready;
   assign rd_en = out_valid && out_ready;

   // No reset on storage; contents are only read behind a valid count
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (wr_en) begin
            wr_r <= wr_r + 1'b1;
         end
         if (rd_en) begin
            rd_r <= rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(wr_en) - (AW+1)'(rd_en);
      end
   end
endmodule // fsc_fifo

`default_nettype wire

// ==== rtl/fsc_pkg.sv ====
/*
 * Types of the serial channel.
 * Assumes nothing of its surroundings.
 */
package fsc_pkg;
   typedef enum logic [4:0] {
      S_IDLE  = 5'h01,
      S_START = 5'h02,
      S_DATA  = 5'h04,
      S_PAR   = 5'h08,
      S_STOP  = 5'h10
   } fsc_state_t;
endpackage

// ==== sim/fsc_remote.sv ====
/* Remote serial device: async frames both ways, slave in sync mode.
   Assumes 16 clocks a bit (baud_div 0) and the channel's own setup. */
`timescale 1ns/10ps
`default_nettype none

module fsc_remote (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Setup shared with the channel; hold drives cts_n, sbyte is the byte sent in sync mode
   input wire logic sync,
   input wire logic msb,
   input wire logic par_en,
   input wire logic par_odd,
   input wire logic hold,
   input wire logic [7:0] sbyte,
   // Line
   input wire logic txd,
   input wire logic sck,
   output logic rxd,
   output logic cts_n,
   // Bytes seen on txd, got_t toggles per byte
   output logic [7:0] got,
   output logic got_t
);
   logic arx = 1'h1;
   logic srx = 1'h1;
   logic [7:0] ab, sb;
   // Reset starts low with no edge, so the counters need a start value
   logic [2:0] si = 3'h0;
   logic [2:0] sc = 3'h0;
   assign rxd = sync ? srx : arx;
   assign cts_n = hold;
   initial got_t = 1'h0;

   // Faults only when the caller asks for them
   task automatic send(input logic [7:0] d, input logic bad_stop,
      input logic bad_par);
      int i;
      @(posedge clk);
      arx <= 1'h0;
      repeat (16) @(posedge clk);
      for (i = 0; i < 8; i++) begin
         arx <= msb ? d[7 - i] : d[i];
         repeat (16) @(posedge clk);
      end
      if (par_en) begin
         arx <= ^d ^ par_odd ^ bad_par;
         repeat (16) @(posedge clk);
      end
      arx <= ~bad_stop;
      repeat (16) @(posedge clk);
      arx <= 1'h1;
   endtask

   // Mid-bit sampling, stop bit not judged here
   always begin
      @(negedge txd);
      if (!sync) begin
         repeat (8) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk);
            ab = msb ? {ab[6:0], txd} : {txd, ab[7:1]};
         end
         repeat (par_en ? 32 : 16) @(posedge clk);
         got = ab;
         got_t = ~got_t;
      end
   end

   always @(negedge sck or negedge resetn)
      if (!resetn) si <= 3'h0;
      else if (sync) begin
         srx <= sbyte[si];
         si <= si + 3'h1;
      end

   always @(posedge sck or negedge resetn)
      if (!resetn) sc <= 3'h0;
      else if (sync) begin
         sb <= {txd, sb[7:1]};
         sc <= sc + 3'h1;
         if (sc == 3'h7) begin
            got <= {txd, sb[7:1]};
            got_t <= ~got_t;
         end
      end
endmodule // fsc_remote
`default_nettype wire

// ==== sim/test_fifo_serial_channel.sv ====
/* Testbench of the serial channel, inputs driven at the falling edge.
   Assumes the channel and the remote model are compiled before it. */
`timescale 1ns/10ps
`default_nettype none

module test_fifo_serial_channel;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic tx_valid = 1'h0, rx_ready = 1'h0, mode_sync = 1'h0;
   logic parity_en = 1'h0, parity_odd = 1'h0, msb_first = 1'h0;
   logic noise_cancel_en = 1'h0, flow_ctrl_en = 1'h1, hold = 1'h1;
   logic stop2 = 1'h0;
   logic [7:0] tx_data = 8'h00, sbyte = 8'h00, rx_data, got;
   logic [3:0] tx_thresh = 4'hF, err_clr_zero = 4'h0, err_flags;
   logic [4:0] rx_thresh = 5'h10;
   logic tx_ready, rx_valid, tx_threshold_event, tx_end_event;
   logic rx_threshold_event, rx_error_event, break_overrun_event;
   logic rxd_in, cts_n_in, txd_out, sck_out, rts_n_out, got_t;
   logic [7:0] q_tx[$], q_rx[$];
   int fail_count = 0;
   int samples_checked = 0;

   always #2 clk = ~clk;

   fsc_channel i_fsc_channel (
      .clk(clk), .resetn(resetn), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .mode_sync(mode_sync), .parity_en(parity_en),
      .parity_odd(parity_odd), .stop2(stop2), .msb_first(msb_first),
      .noise_cancel_en(noise_cancel_en), .flow_ctrl_en(flow_ctrl_en),
      .baud_div(16'h0000), .tx_thresh(tx_thresh), .rx_thresh(rx_thresh),
      .err_clr_zero(err_clr_zero), .err_flags(err_flags),
      .tx_threshold_event(tx_threshold_event),
      .tx_end_event(tx_end_event),
      .rx_threshold_event(rx_threshold_event),
      .rx_error_event(rx_error_event),
      .break_overrun_event(break_overrun_event), .rxd_in(rxd_in),
      .cts_n_in(cts_n_in), .txd_out(txd_out), .sck_out(sck_out),
      .rts_n_out(rts_n_out)
   );

   fsc_remote i_fsc_remote (
      .clk(clk), .resetn(resetn), .sync(mode_sync), .msb(msb_first),
      .par_en(parity_en), .par_odd(parity_odd), .hold(hold),
      .sbyte(sbyte), .txd(txd_out), .sck(sck_out), .rxd(rxd_in),
      .cts_n(cts_n_in), .got(got), .got_t(got_t)
   );

   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask

   task end_sim;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task tmo(input int n, input int lim);
      if (n >= lim) begin
         fail_count++;
         end_sim();
      end
   endtask

   task push(input logic [7:0] b);
      int n;
      tx_data = b;
      tx_valid = 1'h1;
      for (n = 0; n < 99 && tx_ready !== 1'h1; n++) @(negedge clk);
      tmo(n, 99);
      @(negedge clk);
      q_tx.push_back(b);
   endtask

   task flags(input logic [3:0] e);
      chk("err_flags", {4'h0, e}, {4'h0, err_flags});
      chk("rx_error_event", {7'h00, |e[1:0]}, {7'h00, rx_error_event});
      chk("brk_ovr_event", {7'h00, |e[3:2]}, {7'h00, break_overrun_event});
   endtask

   // Pulse, then one cycle for the flag and one for the event
   task clr(input logic [3:0] m);
      err_clr_zero = m;
      @(negedge clk);
      err_clr_zero = 4'h0;
      repeat (2) @(negedge clk);
   endtask

   task wait_end;
      int n;
      repeat (2) @(negedge clk);
      for (n = 0; n < 20000 && tx_end_event !== 1'h1; n++) @(negedge clk);
      tmo(n, 20000);
   endtask

   always @(got_t)
      if (resetn === 1'h1)
         chk("tx byte", q_tx.size() ? q_tx.pop_front() : 8'hxx, got);

   always @(posedge clk)
      if (rx_valid === 1'h1 && rx_ready === 1'h1 && q_rx.size() > 0)
         chk("rx byte", q_rx.pop_front(), rx_data);

   initial begin
      int i, n;
      logic [7:0] b;
      logic [15:0] ef;
      ef = 16'h0521;
      void'($urandom(34));
      repeat (8) @(negedge clk);
      resetn = 1'h1;
      repeat (3) @(negedge clk);
      chk("txd idle", 8'h01, {7'h00, txd_out});
      chk("sck idle", 8'h01, {7'h00, sck_out});
      chk("rts", 8'h00, {7'h00, rts_n_out});
      chk("tx_end", 8'h00, {7'h00, tx_end_event});
      chk("tx_thr", 8'h01, {7'h00, tx_threshold_event});
      flags(4'h0);
      // CTS held off so the whole FIFO stays full
      for (i = 0; i < 16; i++) push(8'($urandom));
      tx_valid = 1'h0;
      repeat (2) @(negedge clk);
      chk("tx_ready", 8'h00, {7'h00, tx_ready});
      chk("tx_thr", 8'h00, {7'h00, tx_threshold_event});
      tx_data = 8'hA5;
      tx_valid = 1'h1;
      repeat (4) @(negedge clk);
      tx_valid = 1'h0;
      chk("txd held", 8'h01, {7'h00, txd_out});
      tx_thresh = 4'h2;
      hold = 1'h0;
      for (n = 0; n < 9000 && tx_threshold_event !== 1'h1; n++)
         @(negedge clk);
      tmo(n, 9000);
      chk("tx_end", 8'h00, {7'h00, tx_end_event});
      wait_end();
      chk("tx left", 8'h00, 8'(q_tx.size()));
      msb_first = 1'h1;
      stop2 = 1'h1;
      push(8'($urandom));
      push(8'($urandom));
      tx_valid = 1'h0;
      for (n = 0; n < 8 && txd_out !== 1'h0; n++) @(negedge clk);
      tmo(n, 8);
      for (n = 0; n < 400 && tx_end_event !== 1'h1; n++) @(negedge clk);
      tmo(n, 400);
      // Two frames of start, eight data and two stop bits, 16 clocks each
      chk("stop2 len", 8'h01, {7'h00, n > 340 && n < 360});
      msb_first = 1'h0;
      stop2 = 1'h0;
      // Host not reading: the seventeenth byte overruns
      flow_ctrl_en = 1'h0;
      noise_cancel_en = 1'h1;
      for (i = 0; i < 17; i++) begin
         b = 8'($urandom);
         if (i < 16) q_rx.push_back(b);
         i_fsc_remote.send(b, 1'h0, 1'h0);
         @(negedge clk);
         if (i == 14) chk("rx_thr", 8'h00, {7'h00, rx_threshold_event});
         if (i == 15) chk("rx_thr", 8'h01, {7'h00, rx_threshold_event});
      end
      flags(4'h8);
      // Flow control on with a full receive FIFO holds the far side off
      flow_ctrl_en = 1'h1;
      repeat (2) @(negedge clk);
      chk("rts", 8'h01, {7'h00, rts_n_out});
      rx_ready = 1'h1;
      for (n = 0; n < 99 && rx_valid !== 1'h0; n++) @(negedge clk);
      tmo(n, 99);
      chk("rx left", 8'h00, 8'(q_rx.size()));
      chk("rts", 8'h00, {7'h00, rts_n_out});
      clr(4'h8);
      flags(4'h0);
      // Framing, parity, break, then a clean frame
      parity_en = 1'h1;
      msb_first = 1'h1;
      parity_odd = 1'($urandom);
      for (i = 0; i < 4; i++) begin
         b = (i == 2) ? 8'h00 : 8'($urandom) | 8'h01;
         if (i == 3) q_rx.push_back(b);
         i_fsc_remote.send(b, i == 0 || i == 2, i == 1);
         @(negedge clk);
         flags(ef[i*4 +: 4]);
         clr(ef[i*4 +: 4]);
         flags(4'h0);
      end
      // Master synchronous, one byte each way
      parity_en = 1'h0;
      msb_first = 1'h0;
      mode_sync = 1'h1;
      sbyte = 8'($urandom);
      q_rx.push_back(sbyte);
      push(8'($urandom));
      tx_valid = 1'h0;
      wait_end();
      repeat (4) @(negedge clk);
      chk("sync rx left", 8'h00, 8'(q_rx.size()));
      chk("sync tx left", 8'h00, 8'(q_tx.size()));
      end_sim();
   end
endmodule // test_fifo_serial_channel
`default_nettype wire
